/* File: src/breaker_status_modbus_regs.sv */
// read-only common dataset slave: breaker status, its validity and the table
// assumes a byte front end that raises rx_frame_end once after the line goes quiet
//
// How it works
// - a frame's protocol address is the register number minus one, so 32000 sits at 0x7CFF.
// - the answer is address, echoed function, byte count of twice the registers, words high first, crc.
// - a 32-bit float spans two registers with the high half in the lower-numbered one.
// - segment one starts at 0x7CFF with 0x7C registers and answers with byte count 0xF8.
// - segment two starts at 0x7D7B with 0x76 registers and answers with byte count 0xEC.
// - segment three starts at 0x7E53 with 0x60 registers and answers with byte count 0xC0.
// - the word at 0x7CFF marks each status bit valid with 1 and invalid with 0.
// - status bit 0 at 0x7D00 is 1 when the breaker is closed and 0 when open.
// - status bit 1 is 1 after a trip of any kind and always 0 with a motor mechanism.
// - status bit 2 is 1 after a trip on an electrical fault or fault test.
// - status bit 3 is 1 with the spring charged and always 0 with a motor mechanism.
// - status bit 5 is 1 when ready to close and always 0 with a motor mechanism.
// - status bit 15 set makes the other bits meaningless; bits 4 and 6 to 14 read 0.
`default_nettype none

module breaker_status_modbus_regs import breaker_dataset_pkg::*; (
   input wire logic clk,                    // system clock, 40 MHz
   input wire logic rst_b,                  // synchronous reset, active low
   input wire logic [7:0] slave_addr,       // own bus address
   input wire logic open_closed_contact,    // breaker closed
   input wire logic trip_contact,           // breaker tripped
   input wire logic fault_trip_contact,     // tripped on electrical fault
   input wire logic spring_charged_contact, // closing spring charged
   input wire logic ready_to_close_contact, // ready to close
   input wire logic motor_mechanism,        // breaker has a motor mechanism
   input wire logic data_unavailable,       // status data not available
   input wire logic [15:0] contact_valid,   // per-bit validity of the status word
   input wire logic upd_we,                 // table word update strobe
   input wire logic [IDX_W-1:0] upd_index,  // table index, address minus 0x7CFF
   input wire logic [15:0] upd_data,        // table word
   input wire logic [7:0] rx_byte,          // received byte
   input wire logic rx_valid,               // rx_byte present, one cycle
   input wire logic rx_frame_end,           // end of frame, one cycle
   output logic [7:0] tx_byte,              // byte to send
   output logic tx_valid,                   // tx_byte present
   input wire logic tx_ready,               // sender takes tx_byte
   output logic tx_busy                     // answer in progress
);

   logic [15:0] status_q, status_d, valid_q, valid_d;
   logic [3:0] rx_cnt_q, rx_cnt_d;
   logic [7:0] rx_buf_q [6];
   logic [15:0] rx_crc, tx_crc, mem_rdata, word;
   logic [15:0] req_start, req_count, start_off;
   logic [16:0] req_end;
   logic [7:0] exc_code, req_func, next_byte;
   logic rx_take, req_ok, slot_free, accepted, load, tx_valid_d, busy_d;
   tx_state_t state_q, state_d;
   logic [7:0] func_q, exc_q;
   logic [6:0] count_q, left_q, left_d;
   logic [IDX_W-1:0] idx_q, idx_d;
   logic crc_byte_q;
   logic [15:0] start_q;

   ////////////////////////////////////////////////////////////////////////////
   // status and validity words, sampled every cycle
   // open or closed
   assign status_d[BIT_CLOSED] = open_closed_contact;
   assign status_d[BIT_TRIPPED] = trip_contact & ~motor_mechanism;
   assign status_d[BIT_FAULT] = fault_trip_contact;
   assign status_d[BIT_SPRING] = spring_charged_contact & ~motor_mechanism;
   assign status_d[BIT_READY] = ready_to_close_contact & ~motor_mechanism;
   assign status_d[BIT_UNAVAIL] = data_unavailable;
   assign status_d[4] = 1'b0;
   assign status_d[14:6] = 9'h000;
   assign valid_d = contact_valid & STATUS_IMPL_MASK;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         status_q <= REG_RESET;
         valid_q <= REG_RESET;
      end else begin
         status_q <= status_d;
         valid_q <= valid_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // request receiver, bytes are dropped while an answer is going out
   assign rx_take = rx_valid && !tx_busy && !rx_frame_end;
   assign rx_cnt_d = rx_frame_end ? 4'h0 : (rx_take && rx_cnt_q != RX_CNT_MAX) ? rx_cnt_q + 4'h1 : rx_cnt_q;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rx_cnt_q <= 4'h0;
      end else begin
         rx_cnt_q <= rx_cnt_d;
      end
   end

   // header bytes in arrival order
   always_ff @(posedge clk) begin
      if (rx_take && rx_cnt_q < REQ_HDR_BYTES) begin
         rx_buf_q[rx_cnt_q[2:0]] <= rx_byte;
      end
   end

   crc16_engine rx_crc_i (
      .clk(clk),
      .rst_b(rst_b),
      .clear(rx_frame_end),
      .feed(rx_take),
      .data_in(rx_byte),
      .crc(rx_crc)
   );

   // field order of a read request
   assign req_func = rx_buf_q[1];
   assign req_start = {rx_buf_q[2], rx_buf_q[3]};
   assign req_count = {rx_buf_q[4], rx_buf_q[5]};
   assign req_end = {1'b0, req_start} + {1'b0, req_count} - 17'h00001;
   assign start_off = req_start - VALIDITY_ADDR;

   assign req_ok = rx_frame_end && !tx_busy && rx_cnt_q == REQ_BYTES && rx_crc == CRC_GOOD &&
                   rx_buf_q[0] == slave_addr && slave_addr != BROADCAST_ADDR;

   // count limit and table range checks
   assign exc_code = (req_func != FUNC_READ) ? EXC_FUNC :
                     (req_count == 16'h0000 || req_count > MAX_REGS) ? EXC_VALUE :
                     (req_start < VALIDITY_ADDR || req_end > TABLE_LAST_ADDR) ? EXC_ADDR : EXC_NONE;

   ////////////////////////////////////////////////////////////////////////////
   // answer sequencer
   assign slot_free = !tx_valid || tx_ready;
   assign accepted = tx_valid && tx_ready;
   // the crc low byte waits for the last data byte to be folded in
   assign load = state_q != TX_IDLE && slot_free && !(state_q == TX_CRCL && tx_valid);

   assign word = (idx_q == VALIDITY_IDX) ? valid_q : (idx_q == STATUS_IDX) ? status_q : mem_rdata;

   // byte for each answer slot, words high byte first
   assign next_byte = (state_q == TX_ADDR) ? slave_addr :
                      (state_q == TX_FUNC) ? func_q :
                      (state_q == TX_COUNT) ? {count_q, 1'b0} :
                      (state_q == TX_DHI) ? word[15:8] :
                      (state_q == TX_DLO) ? word[7:0] :
                      (state_q == TX_CODE) ? exc_q :
                      (state_q == TX_CRCL) ? tx_crc[7:0] : tx_crc[15:8];

   always_comb begin
      state_d = state_q;
      left_d = left_q;
      idx_d = idx_q;
      if (req_ok) begin
         state_d = TX_ADDR;
         left_d = req_count[6:0];
         idx_d = start_off[IDX_W-1:0];
      end else if (load) begin
         unique case (state_q)
            TX_IDLE: state_d = TX_IDLE;
            TX_ADDR: state_d = TX_FUNC;
            TX_FUNC: state_d = (exc_q != EXC_NONE) ? TX_CODE : TX_COUNT;
            TX_COUNT: state_d = TX_DHI;
            TX_DHI: state_d = TX_DLO;
            // next register after the low byte
            TX_DLO: begin
               left_d = left_q - 7'h01;
               idx_d = idx_q + 9'h001;
               state_d = (left_q == 7'h01) ? TX_CRCL : TX_DHI;
            end
            TX_CODE: state_d = TX_CRCL;
            TX_CRCL: state_d = TX_CRCH;
            TX_CRCH: state_d = TX_IDLE;
         endcase
      end
   end

   assign tx_valid_d = load ? 1'b1 : accepted ? 1'b0 : tx_valid;
   assign busy_d = state_d != TX_IDLE || tx_valid_d;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= TX_IDLE;
         left_q <= 7'h00;
         idx_q <= VALIDITY_IDX;
         tx_valid <= 1'b0;
         tx_byte <= 8'h00;
         tx_busy <= 1'b0;
         crc_byte_q <= 1'b0;
      end else begin
         state_q <= state_d;
         left_q <= left_d;
         idx_q <= idx_d;
         tx_valid <= tx_valid_d;
         tx_busy <= busy_d;
         if (load) begin
            tx_byte <= next_byte;
            crc_byte_q <= state_q == TX_CRCL || state_q == TX_CRCH;
         end
      end
   end

   // request fields held for the answer
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         func_q <= 8'h00;
         exc_q <= EXC_NONE;
         count_q <= 7'h00;
         start_q <= 16'h0000;
      end else if (req_ok) begin
         func_q <= (exc_code != EXC_NONE) ? (req_func | EXC_FLAG) : req_func;
         exc_q <= exc_code;
         count_q <= req_count[6:0];
         start_q <= req_start;
      end
   end

   crc16_engine tx_crc_i (
      .clk(clk),
      .rst_b(rst_b),
      .clear(req_ok),
      .feed(accepted && !crc_byte_q),
      .data_in(tx_byte),
      .crc(tx_crc)
   );

   // read address runs one step ahead so the word is ready in time
   dataset_ram table_i (
      .clk(clk),
      .we(upd_we),
      .waddr(upd_index),
      .wdata(upd_data),
      .raddr(idx_d),
      .rdata(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks
   crc_drop_a: assert property (@(posedge clk) disable iff (!rst_b)
      (rx_frame_end && !tx_busy && rx_crc != CRC_GOOD) |=> ##1 !tx_busy)
      else $error("bad crc request was answered");

   answer_head_a: assert property (@(posedge clk) disable iff (!rst_b)
      req_ok |=> ##1 (tx_valid && tx_byte == slave_addr && state_q == TX_FUNC))
      else $error("answer does not open with slave address");

   seg_one_a: assert property (@(posedge clk) disable iff (!rst_b)
      (load && state_q == TX_COUNT && start_q == SEG1_START && {9'h000, count_q} == SEG1_COUNT)
      |=> tx_byte == SEG1_BYTES)
      else $error("segment one byte count wrong");

   seg_two_a: assert property (@(posedge clk) disable iff (!rst_b)
      (load && state_q == TX_COUNT && start_q == SEG2_START && {9'h000, count_q} == SEG2_COUNT)
      |=> tx_byte == SEG2_BYTES)
      else $error("segment two byte count wrong");

   seg_three_a: assert property (@(posedge clk) disable iff (!rst_b)
      (load && state_q == TX_COUNT && start_q == SEG3_START && {9'h000, count_q} == SEG3_COUNT)
      |=> tx_byte == SEG3_BYTES)
      else $error("segment three byte count wrong");

   word_pair_a: assert property (@(posedge clk) disable iff (!rst_b)
      (load && state_q == TX_DHI) |=> (state_q == TX_DLO && idx_q == $past(idx_q) &&
      tx_byte == $past(word[15:8])))
      else $error("high byte not sent before low byte of the same word");

   addr_map_a: assert property (@(posedge clk) disable iff (!rst_b)
      (req_ok && req_start == STATUS_ADDR) |=> idx_q == STATUS_IDX)
      else $error("status address maps to the wrong word");

   valid_word_a: assert property (@(posedge clk) disable iff (!rst_b)
      ##1 valid_q == ($past(contact_valid) & STATUS_IMPL_MASK))
      else $error("validity word does not follow its inputs");

   closed_bit_a: assert property (@(posedge clk) disable iff (!rst_b)
      ##1 status_q[BIT_CLOSED] == $past(open_closed_contact))
      else $error("closed bit does not follow contact");

   motor_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
      $past(motor_mechanism) |-> (status_q[BIT_TRIPPED] == 1'b0 && status_q[BIT_SPRING] == 1'b0 &&
      status_q[BIT_READY] == 1'b0))
      else $error("motor mechanism bits not forced low");

   fault_bit_a: assert property (@(posedge clk) disable iff (!rst_b)
      ##1 status_q[BIT_FAULT] == $past(fault_trip_contact))
      else $error("fault bit does not follow contact");

   reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
      ##1 ((status_q & ~STATUS_IMPL_MASK) == 16'h0000 && status_q[BIT_UNAVAIL] == $past(data_unavailable)))
      else $error("reserved status bits set or availability wrong");

   count_limit_a: assert property (@(posedge clk) disable iff (!rst_b)
      (req_ok && req_func == FUNC_READ && req_count > MAX_REGS) |=> exc_q == EXC_VALUE)
      else $error("oversized read not refused");

endmodule // breaker_status_modbus_regs

`default_nettype wire

/* File: include/breaker_dataset_pkg.sv */
// shared constants, types and the crc step for the breaker status dataset slave
// assumes a byte-level serial front end that delimits frames outside this block
`default_nettype none

package breaker_dataset_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map, protocol addresses (register number minus one)
   localparam logic [15:0] VALIDITY_ADDR = 16'h7CFF;
   localparam logic [15:0] STATUS_ADDR = 16'h7D00;
   localparam logic [16:0] TABLE_LAST_ADDR = 17'h07EB2;
   localparam int TABLE_WORDS = 436;
   localparam int IDX_W = 9;
   localparam logic [8:0] VALIDITY_IDX = 9'h000;
   localparam logic [8:0] STATUS_IDX = 9'h001;
   localparam logic [15:0] REG_RESET = 16'h0000;

   // status bit positions and the mask of implemented bits
   localparam int BIT_CLOSED = 0;
   localparam int BIT_TRIPPED = 1;
   localparam int BIT_FAULT = 2;
   localparam int BIT_SPRING = 3;
   localparam int BIT_READY = 5;
   localparam int BIT_UNAVAIL = 15;
   localparam logic [15:0] STATUS_IMPL_MASK = 16'h802F;

   ////////////////////////////////////////////////////////////////////////////
   // frame layout and function codes
   localparam logic [7:0] FUNC_READ = 8'h03;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [7:0] EXC_VALUE = 8'h03;
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] BROADCAST_ADDR = 8'h00;
   localparam logic [15:0] MAX_REGS = 16'h007D;
   localparam logic [3:0] REQ_BYTES = 4'h8;
   localparam logic [3:0] REQ_HDR_BYTES = 4'h6;
   localparam logic [3:0] RX_CNT_MAX = 4'hF;

   // the three segment reads of the common table
   localparam logic [15:0] SEG1_START = 16'h7CFF;
   localparam logic [15:0] SEG1_COUNT = 16'h007C;
   localparam logic [7:0] SEG1_BYTES = 8'hF8;
   localparam logic [15:0] SEG2_START = 16'h7D7B;
   localparam logic [15:0] SEG2_COUNT = 16'h0076;
   localparam logic [7:0] SEG2_BYTES = 8'hEC;
   localparam logic [15:0] SEG3_START = 16'h7E53;
   localparam logic [15:0] SEG3_COUNT = 16'h0060;
   localparam logic [7:0] SEG3_BYTES = 8'hC0;

   ////////////////////////////////////////////////////////////////////////////
   // crc-16, reflected polynomial, residue of a good frame is zero
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [15:0] CRC_GOOD = 16'h0000;

   typedef enum logic [3:0] {
      TX_IDLE, TX_ADDR, TX_FUNC, TX_COUNT, TX_DHI, TX_DLO, TX_CODE, TX_CRCL, TX_CRCH
   } tx_state_t;

   function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic [7:0] data);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

endpackage

`default_nettype wire

/* File: src/crc16_engine.sv */
// running crc-16 over a byte stream
// assumes feed and clear are synchronous to clk; clear wins over feed
`default_nettype none

module crc16_engine import breaker_dataset_pkg::*; (
   input wire logic clk,          // system clock
   input wire logic rst_b,        // synchronous reset, active low
   input wire logic clear,        // restart at the initial value
   input wire logic feed,         // fold data_in into the sum
   input wire logic [7:0] data_in, // byte to fold in
   output logic [15:0] crc        // running value
);

   ////////////////////////////////////////////////////////////////////////////
   // accumulator
   always_ff @(posedge clk) begin
      if (!rst_b || clear) begin
         crc <= CRC_INIT;
      end else if (feed) begin
         crc <= crc16_step(crc, data_in);
      end
   end

endmodule // crc16_engine

`default_nettype wire

/* File: src/dataset_ram.sv */
// word memory for the dataset table, one write port and one registered read port
// assumes the reader allows one cycle from address to data
`default_nettype none

module dataset_ram import breaker_dataset_pkg::*; (
   input wire logic clk,                // system clock
   input wire logic we,                 // write strobe
   input wire logic [IDX_W-1:0] waddr,  // write index
   input wire logic [15:0] wdata,       // write word
   input wire logic [IDX_W-1:0] raddr,  // read index
   output logic [15:0] rdata            // registered read word
);

   logic [15:0] mem [TABLE_WORDS];

   ////////////////////////////////////////////////////////////////////////////
   // write and registered read
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end

endmodule // dataset_ram

`default_nettype wire

/* File: verif/modbus_master_model.sv */
// modbus master model: sends read requests and takes answer bytes
// assumes one clock domain shared with the slave and its answer handshake
`default_nettype none

module modbus_master_model (
   input wire logic clk,        // system clock
   input wire logic stall_en,   // allow random stalls on the answer side
   output logic [7:0] rx_byte,  // request byte
   output logic rx_valid,       // request byte strobe
   output logic rx_frame_end,   // end of request frame
   output logic tx_ready        // answer byte taken
);
   timeunit 1ns;
   timeprecision 100ps;

   integer seed = 32'h2dd1536a;

   // quiet link at time zero
   initial begin
      rx_byte = 8'h00;
      rx_valid = 1'b0;
      rx_frame_end = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // check sum over a byte list, reflected, start all ones
   function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      return c;
   endfunction

   // answer side sometimes holds back to stretch the slave
   always @(posedge clk) tx_ready <= stall_en ? ($random(seed) % 3 != 0) : 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // request frame order
   task automatic send_req(input logic [7:0] dev, input logic [7:0] fn, input logic [15:0] start,
                           input logic [15:0] cnt, input logic bad);
      logic [7:0] f[$];
      logic [15:0] c;
      f = {dev, fn, start[15:8], start[7:0], cnt[15:8], cnt[7:0]};
      c = crc_of(f) ^ {15'h0000, bad};
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      foreach (f[i]) begin
         @(posedge clk);
         rx_byte <= f[i];
         rx_valid <= 1'b1;
      end
      @(posedge clk);
      rx_byte <= ~f[7];
      rx_valid <= 1'b0;
      rx_frame_end <= 1'b1;
      @(posedge clk);
      rx_frame_end <= 1'b0;
   endtask
endmodule // modbus_master_model

`default_nettype wire

/* File: verif/tb.sv */
// testbench for the breaker status dataset slave, answers checked byte by byte
// assumes the package and the slave design are compiled first
`default_nettype none

module tb import breaker_dataset_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] slave_addr = 8'hFF;
   logic [6:0] sw;
   logic [15:0] cvalid;
   logic upd_we;
   logic [8:0] upd_index;
   logic [15:0] upd_data;
   logic stall_en;
   wire logic [7:0] rx_byte;
   wire logic rx_valid, rx_frame_end, tx_ready;
   logic [7:0] tx_byte;
   logic tx_valid, tx_busy;
   logic [7:0] exp_q[$];
   logic [15:0] mem[0:435];
   logic [15:0] seg_st[3] = '{SEG1_START, SEG2_START, SEG3_START};
   logic [15:0] seg_cn[3] = '{SEG1_COUNT, SEG2_COUNT, SEG3_COUNT};
   integer seed = 32'h2dd1536a;
   int errors = 0;
   int compares = 0;
   int cycles = 0;

   always #12.5 clk = ~clk;

   breaker_status_modbus_regs DUT (.clk(clk), .rst_b(rst_b), .slave_addr(slave_addr),
      .open_closed_contact(sw[0]), .trip_contact(sw[1]), .fault_trip_contact(sw[2]),
      .spring_charged_contact(sw[3]), .ready_to_close_contact(sw[4]), .motor_mechanism(sw[5]),
      .data_unavailable(sw[6]), .contact_valid(cvalid), .upd_we(upd_we), .upd_index(upd_index),
      .upd_data(upd_data), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_frame_end(rx_frame_end),
      .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_busy(tx_busy));

   modbus_master_model master (.clk(clk), .stall_en(stall_en), .rx_byte(rx_byte), .rx_valid(rx_valid),
      .rx_frame_end(rx_frame_end), .tx_ready(tx_ready));

   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask

   // expected word: live validity and status, else table memory
   function automatic logic [15:0] word_at(input logic [15:0] a);
      logic [15:0] i;
      i = a - 16'h7CFF;
      if (i == 16'h0000) return cvalid & 16'h802F;
      if (i == 16'h0001) return {sw[6], 9'h000, sw[4] & ~sw[5], 1'b0, sw[3] & ~sw[5], sw[2], sw[1] & ~sw[5], sw[0]};
      return mem[i];
   endfunction

   // append check sum and queue the whole answer
   task automatic note(input logic [7:0] r[$]);
      logic [15:0] c;
      c = master.crc_of(r);
      exp_q = {exp_q, r, c[7:0], c[15:8]};
   endtask

   task automatic expect_read(input logic [15:0] start, input logic [15:0] cnt);
      logic [7:0] r[$];
      logic [15:0] w;
      r = {slave_addr, FUNC_READ, 8'(cnt * 2)};
      for (int i = 0; i < cnt; i++) begin
         w = word_at(start + 16'(i));
         r.push_back(w[15:8]);
         r.push_back(w[7:0]);
      end
      note(r);
   endtask

   task automatic run(input logic [7:0] dev, input logic [7:0] fn, input logic [15:0] st,
                      input logic [15:0] n, input logic bad);
      master.send_req(dev, fn, st, n, bad);
      repeat (3) @(posedge clk);
      for (int i = 0; i < 3000 && (exp_q.size() != 0 || tx_busy !== 1'b0); i++) @(posedge clk);
      // a missing or stuck answer counts against the run
      chk8("bytes left", 8'h00, 8'(exp_q.size()));
      chk8("busy after answer", 8'h00, {7'h00, tx_busy});
      exp_q.delete();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // each taken answer byte against the oldest note, plus the run ceiling
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         chk8("answer byte", exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx, tx_byte);
      end
      if (cycles == 20000) begin
         errors++;
         conclude();
      end
   end

   // main sequence
   initial begin
      sw = 7'h00;
      cvalid = 16'h0000;
      upd_we = 1'b0;
      upd_index = 9'h000;
      upd_data = 16'h0000;
      stall_en = 1'b0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 436; i++) begin
         mem[i] = (i == 28) ? 16'h440A : (i == 29) ? 16'hC000 : 16'($random(seed));
         @(posedge clk);
         upd_we <= 1'b1;
         upd_index <= 9'(i);
         upd_data <= mem[i];
      end
      @(posedge clk);
      upd_we <= 1'b0;
      for (int k = 0; k < 8; k++) begin
         sw <= 7'($random(seed)) ^ {1'b0, k[1], 5'h00};
         cvalid <= 16'($random(seed));
         stall_en <= k[0];
         repeat (3) @(posedge clk);
         expect_read(VALIDITY_ADDR, 16'h0002);
         run(slave_addr, FUNC_READ, VALIDITY_ADDR, 16'h0002, 1'b0);
      end
      expect_read(16'h7D1B, 16'h0002);
      run(slave_addr, FUNC_READ, 16'h7D1B, 16'h0002, 1'b0);
      expect_read(STATUS_ADDR, 16'h0001);
      run(slave_addr, FUNC_READ, STATUS_ADDR, 16'h0001, 1'b0);
      for (int s = 0; s < 3; s++) begin
         expect_read(seg_st[s], seg_cn[s]);
         run(slave_addr, FUNC_READ, seg_st[s], seg_cn[s], 1'b0);
      end
      note({slave_addr, 8'h84, EXC_FUNC});
      run(slave_addr, 8'h04, VALIDITY_ADDR, 16'h0001, 1'b0);
      note({slave_addr, 8'h83, EXC_VALUE});
      run(slave_addr, FUNC_READ, VALIDITY_ADDR, 16'h007E, 1'b0);
      note({slave_addr, 8'h83, EXC_VALUE});
      run(slave_addr, FUNC_READ, VALIDITY_ADDR, 16'h0000, 1'b0);
      note({slave_addr, 8'h83, EXC_ADDR});
      run(slave_addr, FUNC_READ, SEG3_START, 16'h0061, 1'b0);
      note({slave_addr, 8'h83, EXC_ADDR});
      run(slave_addr, FUNC_READ, 16'h7CFE, 16'h0002, 1'b0);
      run(slave_addr, FUNC_READ, VALIDITY_ADDR, 16'h0001, 1'b1);
      run(8'h11, FUNC_READ, VALIDITY_ADDR, 16'h0001, 1'b0);
      conclude();
   end
endmodule // tb

`default_nettype wire
